// >>> hdl/ptu_pkg.sv
/*
  Shared constants for the PCS test pattern unit: register map, control
  field positions, reset values, polynomial taps and the transmit mode set.
  Assumes a 32-bit APB slave with byte addresses in the low address bits.
*/
package ptu_pkg;

  localparam int ADDR_W = 8;
  localparam int WORD_W = 64;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_STD_CNT   = 8'h08;
  localparam logic [7:0] OFF_VND_LO    = 8'h0C;
  localparam logic [7:0] OFF_VND_HI    = 8'h10;
  localparam logic [7:0] OFF_SEED_A0   = 8'h14;
  localparam logic [7:0] OFF_SEED_A1   = 8'h18;
  localparam logic [7:0] OFF_SEED_A2   = 8'h1C;
  localparam logic [7:0] OFF_SEED_A3   = 8'h20;
  localparam logic [7:0] OFF_SEED_B0   = 8'h24;
  localparam logic [7:0] OFF_SEED_B1   = 8'h28;
  localparam logic [7:0] OFF_SEED_B2   = 8'h2C;
  localparam logic [7:0] OFF_SEED_B3   = 8'h30;
  localparam logic [7:0] OFF_USR_LO    = 8'h34;
  localparam logic [7:0] OFF_USR_HI    = 8'h38;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h3C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h40;

  // control register fields
  localparam int CTL_GEN_EN    = 0;
  localparam int CTL_SQ_SEL    = 1;
  localparam int CTL_ANA_EN    = 2;
  localparam int CTL_DATA_SEL  = 3;
  localparam int CTL_P31_GEN   = 4;
  localparam int CTL_P31_CHK   = 5;
  localparam int CTL_USR_EN    = 6;
  localparam int CTL_PER_LSB   = 8;
  localparam int PER_W         = 4;
  localparam logic [3:0] RST_SQ_PER = 4'h4;

  // status register fields
  localparam int STS_ABILITY   = 0;
  localparam int STS_STD_NZ    = 1;
  localparam int STS_TX_ACT    = 2;

  // interrupt status / mask fields
  localparam int IRQ_W         = 3;
  localparam int IRQ_STD       = 0;
  localparam int IRQ_BITERR    = 1;
  localparam int IRQ_SAT       = 2;

  // scrambler x^58 + x^39 + 1 and long prbs x^31 + x^28 + 1
  localparam int SCR_LEN       = 58;
  localparam int SCR_TAP       = 39;
  localparam int P31_LEN       = 31;
  localparam int P31_TAP       = 28;
  localparam int SEED_WORD_W   = 16;

  localparam logic [SCR_LEN-1:0] RST_SEED  = 58'h0;
  localparam logic [63:0]        RST_USR   = 64'h0;
  localparam logic [31:0]        MAX_STD   = 32'h0000FFFF;
  localparam logic [31:0]        MAX_VND   = 32'hFFFFFFFF;

  typedef enum logic [4:0] {
    MODE_IDLE   = 5'b00001,
    MODE_SQUARE = 5'b00010,
    MODE_PSEUDO = 5'b00100,
    MODE_USER   = 5'b01000,
    MODE_LONG   = 5'b10000
  } ptu_mode_e;

endpackage

// >>> hdl/ptu_lfsr_step.sv
/*
  One clock worth of a self-synchronising scrambler or descrambler,
  x^LEN + x^TAP + 1, bit 0 of the word first in time. Pure combinational.
  Assumes the caller registers the returned state.
*/
`timescale 1ns/1ps
`default_nettype none

module ptu_lfsr_step #(
  parameter int LEN = 58,
  parameter int TAP = 39,
  parameter int W   = 64
) (
  input  wire logic [LEN-1:0] st_in,
  input  wire logic [W-1:0]   din,
  input  wire logic           descr,
  output logic      [W-1:0]   dout,
  output logic      [LEN-1:0] st_out
);

  logic [LEN-1:0] s;
  logic           fb;

  always_comb
  begin
    s    = st_in;
    fb   = 1'b0;
    dout = '0;
    for (int i = 0; i < W; i++)
    begin
      fb      = s[TAP-1] ^ s[LEN-1];
      dout[i] = din[i] ^ fb;
      // descrambler shifts in line bits, scrambler its own output
      s       = {s[LEN-2:0], descr ? din[i] : dout[i]};
    end
    st_out = s;
  end

endmodule

`default_nettype wire

// >>> hdl/ptu_test_pattern.sv
/*
  PCS test pattern unit: square wave generation, seeded pseudo-random, long prbs
  and static user pattern generation and checking, error counters, interrupt.
  Assumes APB master on REF_CLK and tx/rx 64-bit words on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ptu_test_pattern #(
  parameter int ADDR_W = ptu_pkg::ADDR_W,
  parameter int W      = ptu_pkg::WORD_W
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [W-1:0]      TX_DATA_IN,
  output logic      [W-1:0]      TX_DATA_OUT,
  output logic                   TX_TEST_ACTIVE,
  input  wire logic [W-1:0]      RX_DATA,
  input  wire logic              RX_VALID,
  output logic                   IRQ
);

  localparam int SL = ptu_pkg::SCR_LEN;
  localparam int PL = ptu_pkg::P31_LEN;

  typedef struct packed {
    ptu_pkg::ptu_mode_e        mode;
    logic                      gen_en;
    logic                      sq_sel;
    logic                      ana_en;
    logic                      dsel;
    logic                      p31_gen;
    logic                      p31_chk;
    logic                      usr_en;
    logic [ptu_pkg::PER_W-1:0] sq_per;
    logic [SL-1:0]             seed_a;
    logic [SL-1:0]             seed_b;
    logic [63:0]               usr;
    logic [15:0]               std_cnt;
    logic [31:0]               vnd_cnt;
    logic [15:0]               vnd_hi_snap;
    logic [ptu_pkg::IRQ_W-1:0] irq_st;
    logic [ptu_pkg::IRQ_W-1:0] irq_mask;
    logic                      irq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic [W-1:0]              tx_out;
    logic                      tx_act;
    logic [SL-1:0]             tx_scr;
    logic [1:0]                tx_blk;
    logic                      tx_half;
    logic [PL-1:0]             tx_p31;
    logic [ptu_pkg::PER_W-1:0] sq_cnt;
    logic                      sq_ph;
    logic [SL-1:0]             rx_scr;
    logic [1:0]                rx_blk;
    logic                      rx_half;
    logic                      rx_blk_err;
    logic [PL-1:0]             rx_p31;
  } ptu_state_s;

  ptu_state_s q;
  ptu_state_s n;

  logic [SL-1:0] tx_st_in;
  logic [SL-1:0] tx_st_out;
  logic [W-1:0]  tx_scr_word;
  logic [SL-1:0] rx_st_in;
  logic [SL-1:0] rx_st_out;
  logic [W-1:0]  rx_scr_word;
  logic [W-1:0]  rx_scr_din;
  logic [PL-1:0] tx_p31_nxt;
  logic [W-1:0]  tx_p31_word;
  logic [PL-1:0] rx_p31_nxt;
  logic [W-1:0]  rx_p31_err;

  function automatic logic [6:0] popcnt(input logic [W-1:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < W; i++)
    begin
      c = c + {6'h00, v[i]};
    end
    return c;
  endfunction

  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [6:0] inc,
                                          input logic [31:0] lim);
    logic [32:0] s;
    s = {1'b0, a} + {26'h0, inc};
    return (s > {1'b0, lim}) ? lim : s[31:0];
  endfunction

  // seed variant for block index: A, ~A, B, ~B
  function automatic logic [SL-1:0] seed_of(input logic [1:0] blk, input logic [SL-1:0] a,
                                            input logic [SL-1:0] b);
    logic [SL-1:0] s;
    s = blk[1] ? b : a;
    return blk[0] ? ~s : s;
  endfunction

  function automatic logic [15:0] seed_word(input logic [SL-1:0] s, input logic [1:0] idx);
    logic [63:0] x;
    x = {6'h00, s} >> (ptu_pkg::SEED_WORD_W * idx);
    return x[15:0];
  endfunction

  function automatic logic [SL-1:0] seed_set(input logic [SL-1:0] s, input logic [1:0] idx,
                                             input logic [15:0] v);
    logic [63:0] x;
    x = {6'h00, s};
    x[ptu_pkg::SEED_WORD_W*idx +: ptu_pkg::SEED_WORD_W] = v;
    return x[SL-1:0];
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= ptu_pkg::OFF_IRQ_MASK);
  endfunction

  ptu_lfsr_step #(.LEN(SL), .TAP(ptu_pkg::SCR_TAP), .W(W)) u_tx_scr (
    .st_in  (tx_st_in),
    .din    ({W{1'b0}}),
    .descr  (1'b0),
    .dout   (tx_scr_word),
    .st_out (tx_st_out)
  );

  ptu_lfsr_step #(.LEN(SL), .TAP(ptu_pkg::SCR_TAP), .W(W)) u_rx_scr (
    .st_in  (rx_st_in),
    .din    (rx_scr_din),
    .descr  (q.dsel),
    .dout   (rx_scr_word),
    .st_out (rx_st_out)
  );

  ptu_lfsr_step #(.LEN(PL), .TAP(ptu_pkg::P31_TAP), .W(W)) u_tx_p31 (
    .st_in  (q.tx_p31),
    .din    ({W{1'b0}}),
    .descr  (1'b0),
    .dout   (tx_p31_word),
    .st_out (tx_p31_nxt)
  );

  // checker shifts in received bits and so locks by itself
  ptu_lfsr_step #(.LEN(PL), .TAP(ptu_pkg::P31_TAP), .W(W)) u_rx_p31 (
    .st_in  (q.rx_p31),
    .din    (RX_DATA),
    .descr  (1'b1),
    .dout   (rx_p31_err),
    .st_out (rx_p31_nxt)
  );

  // seeded mode reloads at each block start, data mode free-runs
  always_comb
  begin
    tx_st_in = q.tx_scr;
    if (!q.tx_half && !q.dsel)
      tx_st_in = seed_of(q.tx_blk, q.seed_a, q.seed_b);
    rx_st_in = q.rx_scr;
    if (!q.rx_half && !q.dsel)
      rx_st_in = seed_of(q.rx_blk, q.seed_a, q.seed_b);
    rx_scr_din = q.dsel ? RX_DATA : {W{1'b0}};
  end

  logic                      acc;
  logic                      rd;
  logic                      wr;
  logic [ptu_pkg::PER_W-1:0] per;
  logic [ptu_pkg::PER_W-1:0] sc;
  logic                      sp;
  logic [W-1:0]              sq_word;
  logic [W-1:0]              ps_err;
  logic                      ps_run;
  logic                      usr_run;
  logic                      p31_run;
  logic [6:0]                std_inc;
  logic [6:0]                bit_inc;
  logic [31:0]               std_base;
  logic [31:0]               vnd_base;
  logic [31:0]               std_sum;
  logic [ptu_pkg::IRQ_W-1:0] ev;
  logic [ptu_pkg::IRQ_W-1:0] irq_base;

  always_comb
  begin
    n       = q;
    sq_word = '0;
    sc      = q.sq_cnt;
    sp      = q.sq_ph;
    per     = (q.sq_per == '0) ? 4'h1 : q.sq_per;
    std_inc = 7'h00;
    bit_inc = 7'h00;
    ps_err  = '0;

    // apb: one wait state, side effects at the first access edge
    acc       = PSEL & PENABLE & ~q.pready;
    rd        = acc & ~PWRITE;
    wr        = acc & PWRITE & addr_ok(PADDR);
    n.pready  = acc;
    n.pslverr = acc & ~addr_ok(PADDR);
    if (rd)
    begin
      n.prdata = 32'h0;
      case (PADDR)
        ptu_pkg::OFF_CTRL:
          n.prdata = {20'h0, q.sq_per, 1'b0, q.usr_en, q.p31_chk, q.p31_gen,
                      q.dsel, q.ana_en, q.sq_sel, q.gen_en};
        ptu_pkg::OFF_STATUS:
        begin
          n.prdata[ptu_pkg::STS_ABILITY] = 1'b1;
          n.prdata[ptu_pkg::STS_STD_NZ]  = (q.std_cnt != 16'h0);
          n.prdata[ptu_pkg::STS_TX_ACT]  = q.tx_act;
        end
        ptu_pkg::OFF_STD_CNT:  n.prdata = {16'h0, q.std_cnt};
        ptu_pkg::OFF_VND_LO:   n.prdata = {16'h0, q.vnd_cnt[15:0]};
        ptu_pkg::OFF_VND_HI:   n.prdata = {16'h0, q.vnd_hi_snap};
        ptu_pkg::OFF_SEED_A0:  n.prdata = {16'h0, seed_word(q.seed_a, 2'd0)};
        ptu_pkg::OFF_SEED_A1:  n.prdata = {16'h0, seed_word(q.seed_a, 2'd1)};
        ptu_pkg::OFF_SEED_A2:  n.prdata = {16'h0, seed_word(q.seed_a, 2'd2)};
        ptu_pkg::OFF_SEED_A3:  n.prdata = {16'h0, seed_word(q.seed_a, 2'd3)};
        ptu_pkg::OFF_SEED_B0:  n.prdata = {16'h0, seed_word(q.seed_b, 2'd0)};
        ptu_pkg::OFF_SEED_B1:  n.prdata = {16'h0, seed_word(q.seed_b, 2'd1)};
        ptu_pkg::OFF_SEED_B2:  n.prdata = {16'h0, seed_word(q.seed_b, 2'd2)};
        ptu_pkg::OFF_SEED_B3:  n.prdata = {16'h0, seed_word(q.seed_b, 2'd3)};
        ptu_pkg::OFF_USR_LO:   n.prdata = q.usr[31:0];
        ptu_pkg::OFF_USR_HI:   n.prdata = q.usr[63:32];
        ptu_pkg::OFF_IRQ_STAT: n.prdata = {29'h0, q.irq_st};
        ptu_pkg::OFF_IRQ_MASK: n.prdata = {29'h0, q.irq_mask};
        default:               n.prdata = 32'h0;
      endcase
    end
    if (wr)
    begin
      case (PADDR)
        ptu_pkg::OFF_CTRL:
        begin
          n.gen_en  = PWDATA[ptu_pkg::CTL_GEN_EN];
          n.sq_sel  = PWDATA[ptu_pkg::CTL_SQ_SEL];
          n.ana_en  = PWDATA[ptu_pkg::CTL_ANA_EN];
          n.dsel    = PWDATA[ptu_pkg::CTL_DATA_SEL];
          n.p31_gen = PWDATA[ptu_pkg::CTL_P31_GEN];
          n.p31_chk = PWDATA[ptu_pkg::CTL_P31_CHK];
          n.usr_en  = PWDATA[ptu_pkg::CTL_USR_EN];
          n.sq_per  = PWDATA[ptu_pkg::CTL_PER_LSB +: ptu_pkg::PER_W];
        end
        ptu_pkg::OFF_SEED_A0:  n.seed_a = seed_set(q.seed_a, 2'd0, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_A1:  n.seed_a = seed_set(q.seed_a, 2'd1, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_A2:  n.seed_a = seed_set(q.seed_a, 2'd2, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_A3:  n.seed_a = seed_set(q.seed_a, 2'd3, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_B0:  n.seed_b = seed_set(q.seed_b, 2'd0, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_B1:  n.seed_b = seed_set(q.seed_b, 2'd1, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_B2:  n.seed_b = seed_set(q.seed_b, 2'd2, PWDATA[15:0]);
        ptu_pkg::OFF_SEED_B3:  n.seed_b = seed_set(q.seed_b, 2'd3, PWDATA[15:0]);
        ptu_pkg::OFF_USR_LO:   n.usr[31:0]  = PWDATA;
        ptu_pkg::OFF_USR_HI:   n.usr[63:32] = PWDATA;
        ptu_pkg::OFF_IRQ_MASK: n.irq_mask   = PWDATA[ptu_pkg::IRQ_W-1:0];
        default:               n.irq_mask   = q.irq_mask;
      endcase
    end

    // transmit mode; square and pseudo-random outrank long prbs
    if (q.gen_en && q.usr_en)
      n.mode = ptu_pkg::MODE_USER;
    else if (q.gen_en && q.sq_sel)
      n.mode = ptu_pkg::MODE_SQUARE;
    else if (q.gen_en)
      n.mode = ptu_pkg::MODE_PSEUDO;
    else if (q.p31_gen)
      n.mode = ptu_pkg::MODE_LONG;
    else
      n.mode = ptu_pkg::MODE_IDLE;

    // square wave, half period in bit times
    for (int i = 0; i < W; i++)
    begin
      sq_word[i] = sp;
      if (sc == per - 4'h1)
      begin
        sc = '0;
        sp = ~sp;
      end
      else
        sc = sc + 4'h1;
    end

    n.tx_act = (q.mode != ptu_pkg::MODE_IDLE);
    case (q.mode)
      ptu_pkg::MODE_SQUARE:
      begin
        n.tx_out = sq_word;
        n.sq_cnt = sc;
        n.sq_ph  = sp;
      end
      ptu_pkg::MODE_PSEUDO:
      begin
        n.tx_out  = tx_scr_word;
        n.tx_scr  = tx_st_out;
        n.tx_half = ~q.tx_half;
        if (q.tx_half)
          n.tx_blk = q.tx_blk + 2'd1;
      end
      ptu_pkg::MODE_USER:
        n.tx_out = q.usr;
      ptu_pkg::MODE_LONG:
      begin
        n.tx_out = tx_p31_word;
        n.tx_p31 = tx_p31_nxt;
      end
      ptu_pkg::MODE_IDLE:
        n.tx_out = TX_DATA_IN;
      default:
        n.tx_out = TX_DATA_IN;
    endcase
    if (q.mode != ptu_pkg::MODE_SQUARE)
    begin
      n.sq_cnt = '0;
      n.sq_ph  = 1'b1;
    end
    if (q.mode != ptu_pkg::MODE_PSEUDO)
    begin
      n.tx_blk  = 2'd0;
      n.tx_half = 1'b0;
      n.tx_scr  = q.seed_a;
    end

    // receive checks; square select turns off the pseudo-random check only
    usr_run = q.usr_en & RX_VALID;
    ps_run  = q.ana_en & ~q.sq_sel & ~q.usr_en & RX_VALID;
    p31_run = q.p31_chk & RX_VALID;
    if (ps_run)
    begin
      ps_err    = q.dsel ? rx_scr_word : (rx_scr_word ^ RX_DATA);
      n.rx_scr  = rx_st_out;
      n.rx_half = ~q.rx_half;
      n.rx_blk_err = q.rx_half ? 1'b0 : (ps_err != '0);
      if (q.rx_half)
      begin
        n.rx_blk = q.rx_blk + 2'd1;
        if (q.rx_blk_err || (ps_err != '0))
          std_inc = 7'h01;
      end
      bit_inc = popcnt(ps_err);
    end
    else if (!RX_VALID && q.ana_en)
      n.rx_blk = q.rx_blk;
    else
    begin
      n.rx_blk     = 2'd0;
      n.rx_half    = 1'b0;
      n.rx_blk_err = 1'b0;
    end
    if (usr_run)
    begin
      std_inc = (RX_DATA != q.usr) ? 7'h01 : 7'h00;
      bit_inc = popcnt(RX_DATA ^ q.usr);
    end
    if (p31_run)
    begin
      n.rx_p31 = rx_p31_nxt;
      std_inc  = std_inc + popcnt(rx_p31_err);
      bit_inc  = bit_inc + popcnt(rx_p31_err);
    end

    // counters: a read clears, the same cycle's errors still count
    std_base = (rd && PADDR == ptu_pkg::OFF_STD_CNT) ? 32'h0 : {16'h0, q.std_cnt};
    vnd_base = (rd && PADDR == ptu_pkg::OFF_VND_LO) ? 32'h0 : q.vnd_cnt;
    if (rd && PADDR == ptu_pkg::OFF_VND_LO)
      n.vnd_hi_snap = q.vnd_cnt[31:16];
    std_sum   = sat_add(std_base, std_inc, ptu_pkg::MAX_STD);
    n.std_cnt = std_sum[15:0];
    n.vnd_cnt = sat_add(vnd_base, bit_inc, ptu_pkg::MAX_VND);

    ev               = '0;
    ev[ptu_pkg::IRQ_STD]    = (std_inc != 7'h00);
    ev[ptu_pkg::IRQ_BITERR] = (bit_inc != 7'h00);
    ev[ptu_pkg::IRQ_SAT]    = ((std_inc != 7'h00) && (std_sum == ptu_pkg::MAX_STD))
                            || ((bit_inc != 7'h00) && (n.vnd_cnt == ptu_pkg::MAX_VND));
    irq_base = (rd && PADDR == ptu_pkg::OFF_IRQ_STAT) ? '0 : q.irq_st;
    n.irq_st = irq_base | ev;
    n.irq    = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      q        <= '0;
      q.mode   <= ptu_pkg::MODE_IDLE;
      q.sq_per <= ptu_pkg::RST_SQ_PER;
      q.seed_a <= ptu_pkg::RST_SEED;
      q.seed_b <= ptu_pkg::RST_SEED;
      q.usr    <= ptu_pkg::RST_USR;
      q.sq_ph  <= 1'b1;
      q.tx_p31 <= '1;
      q.rx_p31 <= '1;
    end
    else
      q <= n;
  end

  assign PRDATA         = q.prdata;
  assign PREADY         = q.pready;
  assign PSLVERR        = q.pslverr;
  assign TX_DATA_OUT    = q.tx_out;
  assign TX_TEST_ACTIVE = q.tx_act;
  assign IRQ            = q.irq;

endmodule

`default_nettype wire

// >>> verif/ptu_test_pattern_sva.sv
/*
  Port-level assertions for the test pattern unit.
  Assumes binding into ptu_test_pattern, one clock REF_CLK, RST_B low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module ptu_test_pattern_sva #(
  parameter int ADDR_W = 8,
  parameter int W      = 64
) (
  input wire logic              REF_CLK,
  input wire logic              RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic [W-1:0]      TX_DATA_IN,
  input wire logic [W-1:0]      TX_DATA_OUT,
  input wire logic              TX_TEST_ACTIVE,
  input wire logic              IRQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  logic acc;
  logic wctl;
  logic wirq;
  assign acc  = PSEL && PENABLE && !PREADY;
  assign wctl = acc && PWRITE && PADDR == ptu_pkg::OFF_CTRL && (PWDATA[0] || PWDATA[4]);
  assign wirq = acc && (PADDR == ptu_pkg::OFF_IRQ_STAT || PADDR == ptu_pkg::OFF_IRQ_MASK);

  pready_wait_a: assert property (acc |=> PREADY)
    else $error("no answer after one wait state");
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  pready_cause_a: assert property (PREADY |-> $past(acc))
    else $error("ready without access");
  addr_refuse_a: assert property (PREADY && (PADDR[1:0] != 2'h0 || PADDR > 8'h40)
    |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("bad address not refused");
  ability_one_a: assert property (PREADY && !PWRITE && PADDR == ptu_pkg::OFF_STATUS
    |-> PRDATA[ptu_pkg::STS_ABILITY])
    else $error("ability bit low");
  std_width_a: assert property (PREADY && !PWRITE && PADDR == ptu_pkg::OFF_STD_CNT
    |-> PRDATA[31:16] == 16'h0)
    else $error("standard count too wide");
  rdata_hold_a: assert property ($changed(PRDATA) |-> $past(acc && !PWRITE))
    else $error("read data moved without read");
  pass_thru_a: assert property (!TX_TEST_ACTIVE && $past(!TX_TEST_ACTIVE)
    && $past(!TX_TEST_ACTIVE, 2) && $past(RST_B) |-> TX_DATA_OUT == $past(TX_DATA_IN))
    else $error("idle tx not passed through");
  active_cause_a: assert property ($rose(TX_TEST_ACTIVE)
    |-> $past(wctl, 1) || $past(wctl, 2) || $past(wctl, 3))
    else $error("tx test started without enable write");
  irq_clear_a: assert property ($fell(IRQ) |-> $past(wirq, 1) || $past(wirq, 2))
    else $error("interrupt dropped without clear");
endmodule

bind ptu_test_pattern ptu_test_pattern_sva #(.ADDR_W(ADDR_W), .W(W)) u_sva (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_DATA_IN(TX_DATA_IN), .TX_DATA_OUT(TX_DATA_OUT), .TX_TEST_ACTIVE(TX_TEST_ACTIVE),
  .IRQ(IRQ));

`default_nettype wire

// >>> verif/ptu_line_partner.sv
/*
  Far end of the line: loops the transmitted word back with optional bit flips.
  Assumes the bench commands flips and the valid window on clock edges.
*/
`timescale 1ns/1ps
`default_nettype none

module ptu_line_partner (
  input  wire logic        clk,
  input  wire logic [63:0] tx_word,
  input  wire logic        en,
  input  wire logic [63:0] flip,
  output logic      [63:0] rx_word,
  output logic             rx_valid
);
  logic [63:0] line_r;
  always_ff @(posedge clk) line_r <= tx_word ^ flip;
  // idle line shows the inverse, never the stale word
  assign rx_word  = en ? line_r : ~line_r;
  assign rx_valid = en;
endmodule

`default_nettype wire

// >>> verif/ptu_test_pattern_tb.sv
/*
  Self-checking bench for the test pattern unit with a loopback line partner.
  Assumes APB on REF_CLK at 250 MHz and one wait state per transfer.
*/
`timescale 1ns/1ps
`default_nettype none

module ptu_test_pattern_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [63:0] tx_in = 64'h0;
  logic [63:0] tx_out;
  logic        tx_act;
  logic [63:0] rx_data;
  logic        rx_valid;
  logic        irq;
  logic        en = 1'b0;
  logic [63:0] flip = 64'h0;
  logic [63:0] pat [8];
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          total_checks = 0;

  always #2 clk = ~clk;
  always @(posedge clk) tx_in <= tx_in + 64'h0123_4567_89AB_CDEF;

  ptu_test_pattern dut (
    .REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_DATA_IN(tx_in), .TX_DATA_OUT(tx_out), .TX_TEST_ACTIVE(tx_act),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .IRQ(irq));

  ptu_line_partner u_line (.clk(clk), .tx_word(tx_out), .en(en), .flip(flip),
    .rx_word(rx_data), .rx_valid(rx_valid));

  task close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] want, input string what);
    total_checks++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      $display("[ERR] %0t bus hang", $time);
      close_out;
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {1'b0, want}, "register read");
  endtask

  task t_reset;
    rdchk(ptu_pkg::OFF_STATUS, 32'h0000_0001);
    rdchk(ptu_pkg::OFF_CTRL, 32'h0000_0400);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
    apb(1'b1, ptu_pkg::OFF_STATUS, 32'h0);
    rdchk(ptu_pkg::OFF_STATUS, 32'h0000_0001);
    apb(1'b0, 8'h44, 32'h0);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 8'h06, 32'hFFFF_FFFF);
    chk(er, 1'b1, "unaligned write");
  endtask

  task t_user;
    apb(1'b1, ptu_pkg::OFF_USR_LO, 32'h89AB_CDEF);
    apb(1'b1, ptu_pkg::OFF_USR_HI, 32'hC3A5_0F96);
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_0041);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(tx_out, 64'hC3A5_0F96_89AB_CDEF, "user word");
    apb(1'b0, ptu_pkg::OFF_STD_CNT, 32'h0);
    apb(1'b0, ptu_pkg::OFF_VND_LO, 32'h0);
    apb(1'b0, ptu_pkg::OFF_IRQ_STAT, 32'h0);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
    apb(1'b1, ptu_pkg::OFF_IRQ_MASK, 32'h1);
    chk(irq, 1'b0, "irq idle");
    flip <= 64'h11;
    repeat (2) @(posedge clk);
    flip <= 64'h0;
    repeat (4) @(posedge clk);
    chk(irq, 1'b1, "irq raised");
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h2);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
    rdchk(ptu_pkg::OFF_VND_LO, 32'h4);
    rdchk(ptu_pkg::OFF_VND_HI, 32'h0);
    apb(1'b0, ptu_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1, "irq status");
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
  endtask

  task t_square;
    logic [63:0] s0;
    logic [63:0] s1;
    for (int i = 0; i < 64; i++)
    begin
      s0[i] = ((i / 3) % 2) == 0;
      s1[i] = (((i + 64) / 3) % 2) == 0;
    end
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_0306);
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_0307);
    repeat (4) @(posedge clk);
    apb(1'b0, ptu_pkg::OFF_STD_CNT, 32'h0);
    for (int c = 0; c < 12; c++)
    begin
      @(posedge clk);
      #1;
      if (tx_out === s0)
        break;
    end
    chk(tx_out, s0, "square phase");
    @(posedge clk);
    #1 chk(tx_out, s1, "square next");
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
  endtask

  task t_long;
    logic [127:0] b;
    logic         ok;
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_0030);
    repeat (8) @(posedge clk);
    apb(1'b0, ptu_pkg::OFF_STD_CNT, 32'h0);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
    @(posedge clk);
    #1 b[63:0] = tx_out;
    @(posedge clk);
    #1 b[127:64] = tx_out;
    ok = b != 128'h0;
    for (int n = 31; n < 128; n++)
      ok = ok && (b[n] == (b[n-31] ^ b[n-28]));
    chk(ok, 1'b1, "long prbs recurrence");
    @(posedge clk);
    flip <= 64'h0010_0000;
    @(posedge clk);
    flip <= 64'h0;
    repeat (4) @(posedge clk);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h3);
  endtask

  task t_pseudo;
    logic [57:0] sd [2];
    logic [57:0] st;
    logic        o;
    sd[0] = 58'h155_A5A5_0F0F_1234;
    sd[1] = 58'h0C3_3C3C_9876_FEDC;
    en <= 1'b0;
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0);
    for (int k = 0; k < 8; k++)
      apb(1'b1, ptu_pkg::OFF_SEED_A0 + 8'(4 * k), 32'(sd[k / 4] >> (16 * (k % 4))) & 32'hFFFF);
    for (int k = 0; k < 4; k++)
    begin
      st = k[0] ? ~sd[k / 2] : sd[k / 2];
      for (int j = 0; j < 128; j++)
      begin
        o = st[38] ^ st[57];
        pat[2 * k + j / 64][j % 64] = o;
        st = {st[56:0], o};
      end
    end
    apb(1'b0, ptu_pkg::OFF_STD_CNT, 32'h0);
    apb(1'b0, ptu_pkg::OFF_VND_LO, 32'h0);
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_0005);
    for (int c = 0; c < 40; c++)
    begin
      @(posedge clk);
      #1;
      if (tx_out === pat[0])
        break;
    end
    chk(tx_out, pat[0], "seed A start");
    for (int j = 1; j < 16; j++)
    begin
      @(posedge clk);
      en <= 1'b1;
      #1 chk(tx_out, pat[j % 8], "pseudo word");
    end
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h0);
    @(posedge clk);
    flip <= 64'h8000_0000_0000_0000;
    @(posedge clk);
    flip <= 64'h0;
    repeat (4) @(posedge clk);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h1);
    rdchk(ptu_pkg::OFF_VND_LO, 32'h1);
    // data select: free-running scrambler, one flip shows on three taps
    apb(1'b1, ptu_pkg::OFF_CTRL, 32'h0000_000D);
    repeat (6) @(posedge clk);
    apb(1'b0, ptu_pkg::OFF_STD_CNT, 32'h0);
    apb(1'b0, ptu_pkg::OFF_VND_LO, 32'h0);
    @(posedge clk);
    flip <= 64'h1;
    @(posedge clk);
    flip <= 64'h0;
    repeat (4) @(posedge clk);
    rdchk(ptu_pkg::OFF_STD_CNT, 32'h1);
    rdchk(ptu_pkg::OFF_VND_LO, 32'h3);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_user;
    t_square;
    t_long;
    t_pseudo;
    close_out;
  end

  initial
  begin
    #200000;
    err_count++;
    close_out;
  end
endmodule

`default_nettype wire
